// ===== hdl/uotg_alias_reg.sv
// One 16-bit register that takes plain, clear, set and invert writes plus hardware sets.
`timescale 1ns/1ps
module uotg_alias_reg #(
  parameter logic [15:0] WR_MASK = 16'h00ff
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  // Software write
  input  wire logic                wr_i,
  input  wire uotg_pkg::uotg_op_t  op_i,
  input  wire logic [15:0]         data_i,
  // Hardware event sets
  input  wire logic [15:0]         hw_set_i,
  // Register value
  output logic [15:0]              value_o
);

  logic [15:0] value_q;
  logic [15:0] sw_d;
  logic [15:0] value_d;

  always_comb begin
    unique case (op_i)
      uotg_pkg::UOTG_OP_WRITE:  sw_d = data_i;
      uotg_pkg::UOTG_OP_CLEAR:  sw_d = value_q & ~data_i;
      uotg_pkg::UOTG_OP_SET:    sw_d = value_q | data_i;
      uotg_pkg::UOTG_OP_INVERT: sw_d = value_q ^ data_i;
    endcase
  end

  // A hardware set in the same cycle as a clear wins.
  assign value_d = ((wr_i ? sw_d : value_q) | hw_set_i) & WR_MASK;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      value_q <= uotg_pkg::RST_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

  a_alias_clear_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_i && op_i == uotg_pkg::UOTG_OP_CLEAR && hw_set_i == 16'h0000
    |=> value_q == ($past(value_q) & ~$past(data_i)))
    else $error("clear alias changed bits other than the written ones");
  a_alias_set_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_i && op_i == uotg_pkg::UOTG_OP_SET
    |=> value_q == (($past(value_q) | $past(data_i) | $past(hw_set_i)) & WR_MASK))
    else $error("set alias result wrong");
  a_alias_inv_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_i && op_i == uotg_pkg::UOTG_OP_INVERT && hw_set_i == 16'h0000
    |=> value_q == (($past(value_q) ^ $past(data_i)) & WR_MASK))
    else $error("invert alias result wrong");

endmodule

// ===== hdl/uotg_pkg.sv
// Package with register map, field layouts and bus carriers of the USB OTG register slice.
package uotg_pkg;

  localparam int unsigned ADDR_W = 16;

  localparam logic [15:0] OFS_OTG_IRQ_FLAGS  = 16'h8440;
  localparam logic [15:0] OFS_OTG_IRQ_EN     = 16'h8450;
  localparam logic [15:0] OFS_OTG_LINE_STAT  = 16'h8460;
  localparam logic [15:0] OFS_OTG_PULL_CTRL  = 16'h8470;
  localparam logic [15:0] OFS_MOD_PWR_CTRL   = 16'h8480;
  localparam logic [15:0] OFS_BUS_IRQ_FLAGS  = 16'h8600;
  localparam logic [15:0] OFS_BUS_IRQ_EN     = 16'h8610;
  localparam logic [15:0] OFS_ERR_IRQ_FLAGS  = 16'h8620;
  localparam logic [15:0] OFS_ERR_IRQ_EN     = 16'h8630;
  localparam logic [15:0] OFS_XFER_STAT      = 16'h8640;
  localparam logic [15:0] OFS_MOD_CTRL       = 16'h8650;
  localparam logic [15:0] OFS_FUNC_ADDR      = 16'h8660;

  localparam logic [3:0] ALIAS_BASE = 4'h0;
  localparam logic [3:0] ALIAS_CLR  = 4'h4;
  localparam logic [3:0] ALIAS_SET  = 4'h8;
  localparam logic [3:0] ALIAS_INV  = 4'hc;

  localparam logic [15:0] RST_VALUE = 16'h0000;

  // Implemented bit masks of the low halfword.
  localparam logic [15:0] MSK_OTG_IRQ   = 16'h00fd;
  localparam logic [15:0] MSK_OTG_STAT  = 16'h00ae;
  localparam logic [15:0] MSK_OTG_PULL  = 16'h00ff;
  localparam logic [15:0] MSK_PWR_WR    = 16'h0013;
  localparam logic [15:0] MSK_BUS_IRQ   = 16'h00ff;
  localparam logic [15:0] MSK_ERR_IRQ   = 16'h00ff;
  localparam logic [15:0] MSK_CTRL_WR   = 16'h003f;
  localparam logic [15:0] MSK_ADDR      = 16'h00ff;

  localparam int unsigned BIT_USBPWR    = 0;
  localparam int unsigned BIT_ACT_PND   = 7;
  localparam int unsigned BIT_MOD_EN    = 0;
  localparam int unsigned BIT_SE0       = 6;
  localparam int unsigned BIT_J_STATE   = 7;

  typedef enum logic [1:0] {
    UOTG_OP_WRITE,
    UOTG_OP_CLEAR,
    UOTG_OP_SET,
    UOTG_OP_INVERT
  } uotg_op_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
  } uotg_bus_req_t;

  typedef struct packed {
    logic [7:0] otg;
    logic [7:0] bus;
    logic [7:0] err;
  } uotg_events_t;

endpackage

// ===== hdl/uotg_regs.sv
// USB OTG register slice: Avalon-MM slave, alias decode, interrupts and shared pin ownership.
// Function
// - Enabled module owns both shared pins.
// - D+ on port B pin eleven, D- ten.
// - Disabled, powered module returns pins to port.
// - Clear, set, invert aliases at 4, 8, C.
// - Flag registers have only a clear alias.
// - Status registers have no aliases at all.
// - Activity, endpoint, J and SE0 reset undefined.
// - Unimplemented bits and upper halfword read zero.
`timescale 1ns/1ps
module uotg_regs (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  // Avalon-MM slave
  input  wire logic [15:0]        avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  output logic [1:0]              avs_response_o,
  // Events and status from the USB engine
  input  wire uotg_pkg::uotg_events_t events_i,
  input  wire logic [7:0]         otg_line_status_i,
  input  wire logic [7:0]         transfer_status_i,
  input  wire logic               activity_pending_i,
  input  wire logic               line_j_state_i,
  input  wire logic               line_se0_i,
  // Transceiver supply sense pin
  input  wire logic               transceiver_supply_pin_i,
  // USB engine side of the shared pins
  input  wire logic               usb_dp_out_i,
  input  wire logic               usb_dm_out_i,
  input  wire logic               usb_drive_i,
  output logic                    usb_dp_in_o,
  output logic                    usb_dm_in_o,
  // Port B side of the shared pins
  input  wire logic               port_b_pin_eleven_out_i,
  input  wire logic               port_b_pin_eleven_oe_i,
  input  wire logic               port_b_pin_ten_out_i,
  input  wire logic               port_b_pin_ten_oe_i,
  output logic                    port_b_pin_eleven_in_o,
  output logic                    port_b_pin_ten_in_o,
  // Pad signals
  input  wire logic               pad_dp_i,
  input  wire logic               pad_dm_i,
  output logic                    pad_dp_o,
  output logic                    pad_dp_oe_o,
  output logic                    pad_dm_o,
  output logic                    pad_dm_oe_o,
  // Control outputs
  output logic                    module_enable_o,
  output logic [7:0]              pull_control_o,
  output logic [7:0]              function_address_o,
  output logic                    irq_o
);

  localparam int NREG = 12;

  // Synchronisers for pad and supply inputs.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {transceiver_supply_pin_i, pad_dp_i, pad_dm_i};
      sync2_q <= sync1_q;
    end
  end
  wire supply_ok = sync2_q[2];
  wire dp_sync   = sync2_q[1];
  wire dm_sync   = sync2_q[0];

  // Address decode.
  wire [15:0] base_addr = {avs_address_i[15:4], 4'h0};
  wire [3:0]  alias_sel = avs_address_i[3:0];
  logic [NREG-1:0] hit;
  assign hit[0]  = base_addr == uotg_pkg::OFS_OTG_IRQ_FLAGS;
  assign hit[1]  = base_addr == uotg_pkg::OFS_OTG_IRQ_EN;
  assign hit[2]  = base_addr == uotg_pkg::OFS_OTG_LINE_STAT;
  assign hit[3]  = base_addr == uotg_pkg::OFS_OTG_PULL_CTRL;
  assign hit[4]  = base_addr == uotg_pkg::OFS_MOD_PWR_CTRL;
  assign hit[5]  = base_addr == uotg_pkg::OFS_BUS_IRQ_FLAGS;
  assign hit[6]  = base_addr == uotg_pkg::OFS_BUS_IRQ_EN;
  assign hit[7]  = base_addr == uotg_pkg::OFS_ERR_IRQ_FLAGS;
  assign hit[8]  = base_addr == uotg_pkg::OFS_ERR_IRQ_EN;
  assign hit[9]  = base_addr == uotg_pkg::OFS_XFER_STAT;
  assign hit[10] = base_addr == uotg_pkg::OFS_MOD_CTRL;
  assign hit[11] = base_addr == uotg_pkg::OFS_FUNC_ADDR;

  wire is_flag   = hit[0] | hit[5] | hit[7];
  wire is_status = hit[2] | hit[9];
  wire sel_base  = alias_sel == uotg_pkg::ALIAS_BASE;
  wire sel_clr   = alias_sel == uotg_pkg::ALIAS_CLR;
  wire sel_set   = alias_sel == uotg_pkg::ALIAS_SET;
  wire sel_inv   = alias_sel == uotg_pkg::ALIAS_INV;
  wire any_hit   = |hit;
  // Flag registers decode base and clear only; status registers base only.
  wire alias_ok  = sel_base
                 | (sel_clr & ~is_status)
                 | ((sel_set | sel_inv) & ~is_flag & ~is_status);
  wire mapped    = any_hit & alias_ok;

  // Answer after one wait cycle so read data come from a register.
  logic ack_q;
  wire  req = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

  uotg_pkg::uotg_op_t op;
  assign op = sel_clr ? uotg_pkg::UOTG_OP_CLEAR :
              sel_set ? uotg_pkg::UOTG_OP_SET :
              sel_inv ? uotg_pkg::UOTG_OP_INVERT : uotg_pkg::UOTG_OP_WRITE;

  // Low halfword is written whenever byte lane 0 is enabled; with lane 1 off, bits 15:8 are written as zero.
  wire lanes_ok = avs_byteenable_i[0];
  // Writes land at the accepting edge, where waitrequest is low, and not in the wait cycle.
  // A master that is still waiting may rely on no register having changed yet.
  wire wr_ok    = ack_q & avs_write_i & mapped & lanes_ok;
  wire [15:0] wdata = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'h00,
                       avs_writedata_i[7:0]};

  // Plain writes to flag registers clear where a one is written.
  uotg_pkg::uotg_op_t flag_op;
  assign flag_op = uotg_pkg::UOTG_OP_CLEAR;

  logic [15:0] val [NREG];
  logic [15:0] hw_set [NREG];
  assign hw_set[0]  = {8'h00, events_i.otg};
  assign hw_set[5]  = {8'h00, events_i.bus};
  assign hw_set[7]  = {8'h00, events_i.err};
  assign hw_set[1]  = 16'h0000;
  assign hw_set[3]  = 16'h0000;
  assign hw_set[4]  = 16'h0000;
  assign hw_set[6]  = 16'h0000;
  assign hw_set[8]  = 16'h0000;
  assign hw_set[10] = 16'h0000;
  assign hw_set[11] = 16'h0000;
  assign hw_set[2]  = 16'h0000;
  assign hw_set[9]  = 16'h0000;

  localparam logic [15:0] WMASK [NREG] = '{
    uotg_pkg::MSK_OTG_IRQ, uotg_pkg::MSK_OTG_IRQ, 16'h0000, uotg_pkg::MSK_OTG_PULL,
    uotg_pkg::MSK_PWR_WR, uotg_pkg::MSK_BUS_IRQ, uotg_pkg::MSK_BUS_IRQ,
    uotg_pkg::MSK_ERR_IRQ, uotg_pkg::MSK_ERR_IRQ, 16'h0000, uotg_pkg::MSK_CTRL_WR,
    uotg_pkg::MSK_ADDR};

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      if (gi == 2 || gi == 9) begin : g_ro
        assign val[gi] = 16'h0000;
      end else begin : g_rw
        uotg_alias_reg #(
          .WR_MASK (WMASK[gi])
        ) u_reg (
          .ref_clk_i (ref_clk_i),
          .reset_i   (reset_i),
          .wr_i      (wr_ok & hit[gi]),
          .op_i      ((gi == 0 || gi == 5 || gi == 7) ? flag_op : op),
          .data_i    (wdata),
          .hw_set_i  (hw_set[gi]),
          .value_o   (val[gi])
        );
      end
    end
  endgenerate

  // Live status fields; their reset value follows the engine inputs.
  wire [15:0] otg_stat_rd  = {8'h00, otg_line_status_i} & uotg_pkg::MSK_OTG_STAT;
  wire [15:0] xfer_stat_rd = {8'h00, transfer_status_i};
  wire [15:0] pwr_rd  = val[4] | (16'(activity_pending_i) << uotg_pkg::BIT_ACT_PND);
  wire [15:0] ctrl_rd = val[10]
                      | (16'(line_j_state_i) << uotg_pkg::BIT_J_STATE)
                      | (16'(line_se0_i) << uotg_pkg::BIT_SE0);

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (1'b1)
      hit[2]:  rd_mux = otg_stat_rd;
      hit[4]:  rd_mux = pwr_rd;
      hit[9]:  rd_mux = xfer_stat_rd;
      hit[10]: rd_mux = ctrl_rd;
      default: rd_mux = 16'h0000;
    endcase
    for (int i = 0; i < NREG; i++) begin
      if (hit[i] && i != 2 && i != 4 && i != 9 && i != 10) begin
        rd_mux = val[i];
      end
    end
  end

  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else begin
      ack_q <= req;
      if (req) begin
        rdata_q <= (avs_read_i && mapped) ? {16'h0000, rd_mux} : 32'h0000_0000;
        resp_q  <= mapped ? 2'h0 : 2'h3;
      end
    end
  end
  assign avs_readdata_o = rdata_q;
  assign avs_response_o = resp_q;

  // Interrupt: any enabled flag.
  logic irq_q;
  wire  irq_any = |(val[0] & val[1]) | |(val[5] & val[6]) | |(val[7] & val[8]);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_any;
    end
  end
  assign irq_o = irq_q;

  // Shared pin ownership.
  wire mod_en  = val[10][uotg_pkg::BIT_MOD_EN];
  wire port_ok = ~mod_en & supply_ok;
  assign module_enable_o     = mod_en;
  assign pull_control_o      = val[3][7:0];
  assign function_address_o  = val[11][7:0];

  assign pad_dp_o    = mod_en ? usb_dp_out_i : port_b_pin_eleven_out_i;
  assign pad_dp_oe_o = mod_en ? usb_drive_i  : (port_ok & port_b_pin_eleven_oe_i);
  assign pad_dm_o    = mod_en ? usb_dm_out_i : port_b_pin_ten_out_i;
  assign pad_dm_oe_o = mod_en ? usb_drive_i  : (port_ok & port_b_pin_ten_oe_i);
  assign usb_dp_in_o = mod_en & dp_sync;
  assign usb_dm_in_o = mod_en & dm_sync;
  assign port_b_pin_eleven_in_o = port_ok & dp_sync;
  assign port_b_pin_ten_in_o    = port_ok & dm_sync;

  a_pins_usb_owned: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mod_en |-> (pad_dp_oe_o == usb_drive_i && pad_dm_oe_o == usb_drive_i
                && !port_b_pin_eleven_in_o && !port_b_pin_ten_in_o))
    else $error("port logic reaches a pin owned by the USB module");
  a_pins_port_back: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!mod_en && supply_ok) |-> (pad_dp_oe_o == port_b_pin_eleven_oe_i
                                && pad_dm_oe_o == port_b_pin_ten_oe_i))
    else $error("pins not returned to port control");
  a_port_unpowered: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!mod_en && !supply_ok) |-> (!pad_dp_oe_o && !pad_dm_oe_o
                                 && !port_b_pin_eleven_in_o && !port_b_pin_ten_in_o))
    else $error("port reaches the shared pins without transceiver supply");
  a_pin_pairing: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !mod_en |-> (pad_dp_o == port_b_pin_eleven_out_i && pad_dm_o == port_b_pin_ten_out_i))
    else $error("D+ or D- paired with the wrong port pin");
  a_alias_decode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (any_hit && !is_flag && !is_status && !sel_base && !sel_clr && !sel_set && !sel_inv)
    |-> !mapped)
    else $error("alias decode accepts an odd offset");
  a_unmapped_refused: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (req && !mapped) |=> (resp_q == 2'h3 && rdata_q == 32'h0000_0000))
    else $error("unmapped address was not refused");
  a_flag_no_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (req && is_flag && (sel_set || sel_inv)) |=> resp_q == 2'h3)
    else $error("flag register answered a set or invert alias");
  a_status_no_alias: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (req && is_status && !sel_base) |=> resp_q == 2'h3)
    else $error("status register answered an alias");
  a_upper_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ack_q |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper halfword not zero");
  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_ok && hit[5] && events_i.bus == 8'h00) ##1 1'b1 |->
    val[5] == ($past(val[5], 1) & ~$past(wdata, 1)))
    else $error("bus flag clear touched other bits");
  a_set_beats_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_ok && hit[5]) |=> ((val[5] & $past(hw_set[5])) == $past(hw_set[5])))
    else $error("bus event lost against a clear in the same cycle");
  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    irq_o == $past(irq_any))
    else $error("interrupt does not follow the enabled flags");

  // A new request sees one wait cycle, then is accepted.
  sequence s_req_start;
    (avs_read_i || avs_write_i) && !ack_q;
  endsequence
  sequence s_req_accept;
    ack_q && !avs_waitrequest_o;
  endsequence
  a_wait_one_cycle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    s_req_start |-> avs_waitrequest_o ##1 s_req_accept)
    else $error("request not accepted after exactly one wait cycle");
  a_answer_stands: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !req |=> ($stable(avs_readdata_o) && $stable(avs_response_o)))
    else $error("read data or response changed without a request");

endmodule

// ===== verif/tb_uotg_regs.sv
// Self-checking testbench of the USB OTG register slice over its Avalon-MM port.
`timescale 1ns/1ps
module tb_uotg_regs;
  logic                   ref_clk_i;
  logic                   reset_i;
  logic [15:0]            adr;
  logic                   rd_s;
  logic                   wr_s;
  logic [31:0]            wdat;
  logic [3:0]             be;
  logic [31:0]            rdat;
  logic                   wreq;
  logic [1:0]             rsp;
  uotg_pkg::uotg_events_t ev;
  logic [7:0]             otg_st;
  logic [7:0]             xfer_st;
  logic                   act;
  logic                   jst;
  logic                   se0;
  logic                   sup;
  logic [2:0]             usb_o;
  logic [3:0]             prt;
  logic [1:0]             pad_i;
  logic                   dp_in;
  logic                   dm_in;
  logic                   b11_in;
  logic                   b10_in;
  logic [3:0]             pad;
  logic                   men;
  logic [7:0]             pull;
  logic [7:0]             fadr;
  logic                   irq;
  logic [31:0]            rdv;
  logic [1:0]             rsv;
  int                     failures;
  int                     n_checks;

  uotg_regs uotg_regs_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .avs_response_o(rsp),
    .events_i(ev), .otg_line_status_i(otg_st), .transfer_status_i(xfer_st),
    .activity_pending_i(act), .line_j_state_i(jst), .line_se0_i(se0),
    .transceiver_supply_pin_i(sup), .usb_dp_out_i(usb_o[0]), .usb_dm_out_i(usb_o[1]),
    .usb_drive_i(usb_o[2]), .usb_dp_in_o(dp_in), .usb_dm_in_o(dm_in),
    .port_b_pin_eleven_out_i(prt[0]), .port_b_pin_eleven_oe_i(prt[1]),
    .port_b_pin_ten_out_i(prt[2]), .port_b_pin_ten_oe_i(prt[3]),
    .port_b_pin_eleven_in_o(b11_in), .port_b_pin_ten_in_o(b10_in),
    .pad_dp_i(pad_i[0]), .pad_dm_i(pad_i[1]), .pad_dp_o(pad[0]), .pad_dp_oe_o(pad[1]),
    .pad_dm_o(pad[2]), .pad_dm_oe_o(pad[3]), .module_enable_o(men),
    .pull_control_o(pull), .function_address_o(fadr), .irq_o(irq)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus access; the request stands until waitrequest is sampled low at a rising edge.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    adr  <= a;
    wdat <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge ref_clk_i);
    end while (wreq !== 1'b0);
    rdv = rdat;
    rsv = rsp;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  task automatic wr_c(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    acc(1'b1, a, d);
    chk_rsp(rsv, r);
  endtask

  task automatic rd_c(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
    acc(1'b0, a, 32'h0);
    chk_val(rdv, e);
    chk_rsp(rsv, r);
  endtask

  task automatic settle();
    repeat (3) @(negedge ref_clk_i);
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    give_verdict();
  end

  initial begin
    failures = 0; n_checks = 0; reset_i = 1'b1; adr = 16'h0; rd_s = 1'b0; wr_s = 1'b0;
    wdat = 32'h0; be = 4'hf; ev = '0; otg_st = 8'hff; xfer_st = 8'h5a; act = 1'b1;
    jst = 1'b1; se0 = 1'b0; sup = 1'b1; usb_o = 3'h6; prt = 4'hb; pad_i = 2'h1;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h0, 2'h0);
    rd_c(uotg_pkg::OFS_FUNC_ADDR, 32'h0, 2'h0);
    $display("reset test done");
    wr_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'hffffffff, 2'h0);
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h000000fd, 2'h0);
    wr_c(uotg_pkg::OFS_OTG_IRQ_EN + 16'h4, 32'h5, 2'h0);
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h000000f8, 2'h0);
    wr_c(uotg_pkg::OFS_OTG_IRQ_EN + 16'h8, 32'h3, 2'h0);
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h000000f9, 2'h0);
    wr_c(uotg_pkg::OFS_OTG_IRQ_EN + 16'hc, 32'hff, 2'h0);
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h00000004, 2'h0);
    be <= 4'h0;
    wr_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'hff, 2'h0);
    be <= 4'hf;
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h00000004, 2'h0);
    $display("alias test done");
    @(posedge ref_clk_i);
    ev <= '{otg: 8'hff, bus: 8'ha5, err: 8'h3c};
    @(posedge ref_clk_i);
    ev <= '0;
    rd_c(uotg_pkg::OFS_OTG_IRQ_FLAGS, 32'h000000fd, 2'h0);
    rd_c(uotg_pkg::OFS_BUS_IRQ_FLAGS, 32'h000000a5, 2'h0);
    wr_c(uotg_pkg::OFS_OTG_IRQ_EN, 32'h0, 2'h0);
    settle();
    chk_val({31'h0, irq}, 32'h0);
    wr_c(uotg_pkg::OFS_BUS_IRQ_EN, 32'h1, 2'h0);
    settle();
    chk_val({31'h0, irq}, 32'h1);
    for (int i = 2; i < 4; i++) begin
      wr_c(uotg_pkg::OFS_BUS_IRQ_FLAGS + 16'(i * 4), 32'hff, 2'h3);
      rd_c(uotg_pkg::OFS_ERR_IRQ_FLAGS + 16'(i * 4), 32'h0, 2'h3);
    end
    rd_c(uotg_pkg::OFS_BUS_IRQ_FLAGS, 32'h000000a5, 2'h0);
    wr_c(uotg_pkg::OFS_BUS_IRQ_FLAGS + 16'h4, 32'h1, 2'h0);
    rd_c(uotg_pkg::OFS_BUS_IRQ_FLAGS, 32'h000000a4, 2'h0);
    settle();
    chk_val({31'h0, irq}, 32'h0);
    wr_c(uotg_pkg::OFS_ERR_IRQ_FLAGS, 32'h0c, 2'h0);
    rd_c(uotg_pkg::OFS_ERR_IRQ_FLAGS, 32'h00000030, 2'h0);
    $display("interrupt test done");
    rd_c(uotg_pkg::OFS_OTG_LINE_STAT, 32'h000000ae, 2'h0);
    rd_c(uotg_pkg::OFS_XFER_STAT, 32'h0000005a, 2'h0);
    for (int i = 1; i < 4; i++) begin
      rd_c(uotg_pkg::OFS_OTG_LINE_STAT + 16'(i * 4), 32'h0, 2'h3);
      wr_c(uotg_pkg::OFS_XFER_STAT + 16'(i * 4), 32'hff, 2'h3);
    end
    rd_c(16'h8490, 32'h0, 2'h3);
    rd_c(uotg_pkg::OFS_OTG_IRQ_EN + 16'h2, 32'h0, 2'h3);
    wr_c(uotg_pkg::OFS_MOD_PWR_CTRL, 32'hffff, 2'h0);
    rd_c(uotg_pkg::OFS_MOD_PWR_CTRL, 32'h00000093, 2'h0);
    wr_c(uotg_pkg::OFS_FUNC_ADDR, 32'h1ff, 2'h0);
    wr_c(uotg_pkg::OFS_OTG_PULL_CTRL, 32'ha5, 2'h0);
    settle();
    chk_val({24'h0, fadr}, 32'hff);
    chk_val({24'h0, pull}, 32'ha5);
    $display("status test done");
    settle();
    chk_val({28'h0, pad}, 32'hb);
    chk_val({30'h0, b10_in, b11_in}, 32'h1);
    wr_c(uotg_pkg::OFS_MOD_CTRL, 32'h1, 2'h0);
    rd_c(uotg_pkg::OFS_MOD_CTRL, 32'h00000081, 2'h0);
    settle();
    chk_val({31'h0, men}, 32'h1);
    chk_val({28'h0, pad}, 32'he);
    chk_val({28'h0, dm_in, dp_in, b10_in, b11_in}, 32'h4);
    @(posedge ref_clk_i);
    usb_o <= 3'h1;
    settle();
    chk_val({28'h0, pad}, 32'h1);
    wr_c(uotg_pkg::OFS_MOD_CTRL + 16'h4, 32'h1, 2'h0);
    settle();
    chk_val({31'h0, men}, 32'h0);
    chk_val({28'h0, pad}, 32'hb);
    @(posedge ref_clk_i);
    sup <= 1'b0;
    settle();
    chk_val({28'h0, pad}, 32'h1);
    chk_val({30'h0, b10_in, b11_in}, 32'h0);
    $display("pin test done");
    give_verdict();
  end
endmodule
